// >>> rtl/evt_irq_pkg.sv
package evt_irq_pkg;
    // Register offset of the interrupt register on the card bus
    localparam logic [2:0] INT_REG_OFS = 3'h6;
    // Field positions
    localparam int EXT_PEND_BIT = 6;
    localparam int LOAD_PEND_BIT = 5;
    localparam int TMR_PEND_BIT = 4;
    localparam int EXT_EN_BIT = 2;
    localparam int LOAD_EN_BIT = 1;
    localparam int TMR_EN_BIT = 0;
    // Value of the interrupt register after reset
    localparam logic [7:0] INT_REG_RST = 8'h00;
    // Mask of writable enable bits
    localparam logic [7:0] INT_EN_MASK = 8'h07;
    // Host controller register offsets (Avalon word index)
    localparam logic [1:0] HC_CMD_OFS = 2'h0;
    localparam logic [1:0] HC_STAT_OFS = 2'h1;
    localparam logic [1:0] HC_IMASK_OFS = 2'h2;
    localparam logic [1:0] HC_ISTAT_OFS = 2'h3;
    // Status word reset value
    localparam logic [7:0] HC_ZERO = 8'h00;
endpackage : evt_irq_pkg

// >>> rtl/evt_irq_if.sv
interface evt_irq_if;
    // Card bus between host and device
    logic [2:0] addr;
    logic wr;
    logic rd;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic irq;
    // Event status clears requested by the host
    logic ext_clr;
    logic load_clr;
    logic tmr_clr;
    modport dev (input addr, wr, rd, wdata, ext_clr, load_clr, tmr_clr,
        output rdata, irq);
    modport host (output addr, wr, rd, wdata, ext_clr, load_clr, tmr_clr,
        input rdata, irq);
endinterface : evt_irq_if

// >>> rtl/event_interrupt_register.sv
// Notes on behaviour
// - Interrupt register sits at offset 6
// - Bits 7 and 3 read zero
// - Bit 6 shows external pending
// - External pending holds until disabled or cleared
// - Bit 5 shows load pending
// - Load pending holds until disabled or cleared
// - Bit 4 shows timer pending
// - Timer pending holds until disabled or cleared
// - Host writes zero to pending bits
// - Bit 2 enables external interrupts
// - Bit 1 enables load interrupts
// - Bit 0 enables timer interrupts
// - Load flag sets on load rising edge
// - Each timer expiry is a timer event
module event_interrupt_register
    import evt_irq_pkg::*;
(
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // Event sources
    input wire logic i_external_event_flag,
    input wire logic i_load_in,
    input wire logic i_timer_expiry,
    // Card side
    evt_irq_if.dev bus
);
    ////////////////////////////////////////////////////////////////////////
    logic [2:0] en_q; // Enable bits ext/load/timer
    logic [2:0] flag_q; // Event status flags
    logic [2:0] pend; // Pending = flag and enable
    logic load_in_q; // Previous load input level
    logic [2:0] evt; // Event pulses
    logic [2:0] clr; // Status clears
    logic [7:0] rdata_q;
    logic irq_q;

    // Event pulses: external, load rising edge, timer expiry
    assign evt = {i_external_event_flag, i_load_in & ~load_in_q,
        i_timer_expiry};
    assign clr = {bus.ext_clr, bus.load_clr, bus.tmr_clr};
    assign pend = flag_q & en_q;

    ////////////////////////////////////////////////////////////////////////
    // Load input edge history
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            load_in_q <= 1'b0;
        end else begin
            load_in_q <= i_load_in;
        end
    end

    // Sticky event flags; set wins over clear
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            flag_q <= 3'h0;
        end else begin
            flag_q <= (flag_q & ~clr) | evt;
        end
    end

    // Enable bits written at offset 6; pending bits ignored on write
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            en_q <= INT_REG_RST[2:0];
        end else if (bus.wr && bus.addr == INT_REG_OFS) begin
            en_q <= bus.wdata[2:0] & INT_EN_MASK[2:0];
        end
    end

    // Read data, reserved bits zero
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            rdata_q <= INT_REG_RST;
        end else if (bus.rd && bus.addr == INT_REG_OFS) begin
            rdata_q <= {1'b0, pend, 1'b0, en_q};
        end else begin
            rdata_q <= 8'h00;
        end
    end

    // Interrupt request line
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= |pend;
        end
    end

    assign bus.rdata = rdata_q;
    assign bus.irq = irq_q;
endmodule : event_interrupt_register

// >>> rtl/event_irq_host.sv
// Local design decision: the Avalon-MM register port.
module event_irq_host
    import evt_irq_pkg::*;
(
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // Avalon-MM slave
    input wire logic [1:0] i_address,
    input wire logic i_read,
    input wire logic i_write,
    input wire logic [31:0] i_writedata,
    output logic [31:0] o_readdata,
    output logic o_waitrequest,
    output logic o_irq,
    // Card side
    evt_irq_if.host bus
);
    ////////////////////////////////////////////////////////////////////////
    typedef enum logic [2:0] {
        S_IDLE = 3'b001,
        S_CARD = 3'b010,
        S_DONE = 3'b100
    } st_e;
    st_e st_q;
    logic [2:0] addr_q;
    logic wr_q, rd_q;
    logic [7:0] wdata_q;
    logic [2:0] clr_q; // Clear pulses ext/load/timer
    logic [7:0] stat_q; // Last card read data
    logic [7:0] imask_q;
    logic [7:0] istat_q;
    logic irq_seen_q; // Card irq one cycle ago
    logic rd_late_q; // Card read strobe one cycle late
    logic [31:0] rdata_q;
    logic wait_q;
    logic irq_q;
    logic cmd_w;
    assign cmd_w = i_write && st_q == S_IDLE && i_address == HC_CMD_OFS;

    ////////////////////////////////////////////////////////////////////////
    // Command: [9] read, [8] write, [7:0] data; [12:10] clears
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            st_q <= S_IDLE;
            wr_q <= 1'b0;
            rd_q <= 1'b0;
            addr_q <= INT_REG_OFS;
            wdata_q <= HC_ZERO;
            clr_q <= 3'h0;
        end else begin
            wr_q <= 1'b0;
            rd_q <= 1'b0;
            clr_q <= 3'h0;
            unique case (st_q)
                S_IDLE: begin
                    if (cmd_w) begin
                        addr_q <= INT_REG_OFS;
                        // Pending and reserved bits forced to zero
                        wdata_q <= i_writedata[7:0] & INT_EN_MASK;
                        wr_q <= i_writedata[8];
                        rd_q <= i_writedata[9];
                        clr_q <= i_writedata[12:10];
                        st_q <= S_CARD;
                    end else if (i_read || i_write) begin
                        st_q <= S_DONE;
                    end
                end
                S_CARD: st_q <= S_DONE;
                S_DONE: st_q <= S_IDLE;
            endcase
        end
    end

    // Capture card read data one cycle after read strobe
    // Card read data is registered, so it stands a cycle after rd
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            stat_q <= HC_ZERO;
            rd_late_q <= 1'b0;
        end else begin
            rd_late_q <= rd_q;
            if (rd_late_q) begin
                stat_q <= bus.rdata;
            end
        end
    end

    // Interrupt mask and sticky status (card irq rising edge)
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            imask_q <= HC_ZERO;
            istat_q <= HC_ZERO;
            irq_q <= 1'b0;
            irq_seen_q <= 1'b0;
        end else begin
            irq_seen_q <= bus.irq;
            if (st_q == S_DONE && i_write && i_address == HC_IMASK_OFS) begin
                imask_q <= i_writedata[7:0];
            end
            if (st_q == S_DONE && i_write && i_address == HC_ISTAT_OFS) begin
                istat_q <= (istat_q & ~i_writedata[7:0])
                    | {7'h00, bus.irq & ~irq_seen_q};
            end else begin
                istat_q <= istat_q | {7'h00, bus.irq & ~irq_seen_q};
            end
            irq_q <= |(istat_q & imask_q);
        end
    end

    // Avalon answer: waitrequest drops in S_DONE
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            rdata_q <= 32'h0;
            wait_q <= 1'b1;
        end else begin
            // Low exactly while the state is S_DONE
            wait_q <= !(st_q == S_CARD
                || (st_q == S_IDLE && !cmd_w && (i_read || i_write)));
            unique case (i_address)
                HC_STAT_OFS: rdata_q <= {23'h0, bus.irq, stat_q};
                HC_IMASK_OFS: rdata_q <= {24'h0, imask_q};
                HC_ISTAT_OFS: rdata_q <= {24'h0, istat_q};
                default: rdata_q <= 32'h0;
            endcase
        end
    end

    assign o_waitrequest = wait_q;
    assign o_readdata = rdata_q;
    assign o_irq = irq_q;
    assign bus.addr = addr_q;
    assign bus.wr = wr_q;
    assign bus.rd = rd_q;
    assign bus.wdata = wdata_q;
    assign {bus.ext_clr, bus.load_clr, bus.tmr_clr} = clr_q;
endmodule : event_irq_host

// >>> tb/evt_irq_props.sv
module evt_irq_props
    import evt_irq_pkg::*;
(
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // Card bus
    input wire logic [2:0] addr,
    input wire logic wr,
    input wire logic rd,
    input wire logic [7:0] wdata,
    input wire logic [7:0] rdata,
    input wire logic irq,
    input wire logic ext_clr,
    input wire logic load_clr,
    input wire logic tmr_clr
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);
    logic [2:0] en_q; // Shadow of the enable bits
    ////////////////////////////////////////////////////////////////////
    // Follow enable writes
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            en_q <= INT_REG_RST[2:0];
        end else if (wr && addr == INT_REG_OFS) begin
            en_q <= wdata[2:0];
        end
    end
    ////////////////////////////////////////////////////////////////////
    chk_card_offset: assert property ((wr || rd) |-> addr == 3'h6)
        else $error("card access off offset");
    chk_rsvd_zero: assert property (rd |=> !rdata[7] && !rdata[3])
        else $error("reserved bit reads one");
    chk_wr_zeros: assert property (wr |-> wdata[7:3] == 5'h00)
        else $error("write sets status bits");
    chk_en_readback: assert property (
        rd |=> rdata[2:0] == $past(en_q))
        else $error("enable readback wrong");
    chk_ext_masked: assert property (
        rd |=> !rdata[6] || $past(en_q[2]))
        else $error("external pending while disabled");
    chk_load_masked: assert property (
        rd |=> !rdata[5] || $past(en_q[1]))
        else $error("load pending while disabled");
    chk_tmr_masked: assert property (
        rd |=> !rdata[4] || $past(en_q[0]))
        else $error("timer pending while disabled");
    chk_irq_idle: assert property ((en_q == 3'h0)[*3] |-> !irq)
        else $error("irq with all sources disabled");
    // Main scenarios
    cover property ($rose(irq));
    cover property (ext_clr);
    cover property (load_clr || tmr_clr);
    cover property (rd ##1 rdata[5]);
endmodule : evt_irq_props

// >>> tb/testbench.sv
module testbench
    import evt_irq_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic i_clk = 1'b0;
    logic i_rst = 1'b1;
    logic i_external_event_flag = 1'b0;
    logic i_load_in = 1'b0;
    logic i_timer_expiry = 1'b0;
    logic [1:0] i_address = 2'h0;
    logic i_read = 1'b0;
    logic i_write = 1'b0;
    logic [31:0] i_writedata = 32'h0;
    logic [31:0] o_readdata;
    logic o_waitrequest;
    logic o_irq;
    logic [31:0] q; // Scratch read data
    int num_errors = 0;
    int total_checks = 0;
    int cycles = 0;
    evt_irq_if bus_if ();
    event_interrupt_register event_interrupt_register_i (.i_clk(i_clk),
        .i_rst(i_rst), .i_external_event_flag(i_external_event_flag), .i_load_in(i_load_in),
        .i_timer_expiry(i_timer_expiry), .bus(bus_if));
    event_irq_host event_irq_host_i (.i_clk(i_clk), .i_rst(i_rst),
        .i_address(i_address), .i_read(i_read), .i_write(i_write),
        .i_writedata(i_writedata), .o_readdata(o_readdata),
        .o_waitrequest(o_waitrequest), .o_irq(o_irq), .bus(bus_if));
    evt_irq_props evt_irq_props_i (.i_clk(i_clk), .i_rst(i_rst),
        .addr(bus_if.addr), .wr(bus_if.wr), .rd(bus_if.rd),
        .wdata(bus_if.wdata), .rdata(bus_if.rdata), .irq(bus_if.irq),
        .ext_clr(bus_if.ext_clr), .load_clr(bus_if.load_clr),
        .tmr_clr(bus_if.tmr_clr));
    ////////////////////////////////////////////////////////////////////
    initial begin
        forever #10 i_clk = ~i_clk;
    end
    // Cut a hang short
    always @(posedge i_clk) begin
        cycles++;
        if (cycles == 3000) begin
            num_errors++;
            conclude();
        end
    end
    task conclude();
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : conclude
    task check(input string name, input logic [31:0] seen, exp);
        total_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    // One Avalon transfer, held until waitrequest is low
    task av(input logic w, input logic [1:0] a, input logic [31:0] d);
        @(posedge i_clk);
        i_address <= a;
        i_write <= w;
        i_read <= !w;
        i_writedata <= d;
        do @(posedge i_clk); while (o_waitrequest !== 1'b0);
        q = o_readdata;
        i_read <= 1'b0;
        i_write <= 1'b0;
    endtask : av
    // Read the card register, then the status word
    task card();
        av(1'b1, HC_CMD_OFS, 32'h200);
        av(1'b0, HC_STAT_OFS, 32'h0);
    endtask : card
    // Event, hide, show again, clear for source k
    task source(input int k);
        logic [7:0] pend;
        logic [2:0] part;
        pend = 8'h40 >> k;
        part = 3'h7 ^ (3'h4 >> k);
        @(posedge i_clk);
        i_external_event_flag <= (k == 0);
        i_load_in <= (k == 1);
        i_timer_expiry <= (k == 2);
        @(posedge i_clk);
        i_external_event_flag <= 1'b0;
        i_load_in <= 1'b0;
        i_timer_expiry <= 1'b0;
        card();
        check("pending", q, {23'h0, 1'b1, INT_EN_MASK | pend});
        av(1'b0, HC_ISTAT_OFS, 32'h0);
        check("irq status", q, 32'h1);
        check("host irq", {31'h0, o_irq}, 32'h1);
        av(1'b1, HC_CMD_OFS, {24'h1, 5'h0, part});
        card();
        check("hidden", q, {24'h0, 5'h0, part});
        av(1'b1, HC_CMD_OFS, 32'h107);
        card();
        check("held", q, {24'h1, INT_EN_MASK | pend});
        av(1'b1, HC_CMD_OFS, 32'h1000 >> k);
        card();
        check("cleared", q, {24'h0, INT_EN_MASK});
        av(1'b1, HC_ISTAT_OFS, 32'h1);
        repeat (2) @(posedge i_clk);
        check("host irq", {31'h0, o_irq}, 32'h0);
        $display("source %0d done", k);
    endtask : source
    ////////////////////////////////////////////////////////////////////
    initial begin
        repeat (2) @(posedge i_clk);
        i_rst <= 1'b0;
        av(1'b1, HC_IMASK_OFS, 32'h1);
        av(1'b1, HC_CMD_OFS, 32'h107);
        for (int k = 0; k < 3; k++) begin
            source(k);
        end
        conclude();
    end
endmodule : testbench
